// [include/fdcsm_params.svh]
// Constants for the strap-selected system-mode logic
`ifndef FDCSM_PARAMS_SVH
`define FDCSM_PARAMS_SVH

// ============================================================
// Field positions
`define FDCSM_PWR_IDLE_BIT   4

// ============================================================
// Timing counts (clock cycles)
`define FDCSM_SYNC_STAGES    2
`define FDCSM_STRAP_SETTLE   2'd3

// ============================================================
// Reset values of outputs
`define FDCSM_DMA_EN_RST     1'b0
`define FDCSM_TERM_CNT_RST   1'b0
`define FDCSM_STATUS_OE_RST  1'b0
`define FDCSM_DENSITY_RST    1'b0
`define FDCSM_SHARED_RST     1'b0
`define FDCSM_TRACK_RST      1'b0

`endif

// [include/fdcsm_pkg.sv]
// Types shared by the system-mode logic
package fdcsm_pkg;

  // ============================================================
  // Host-compatibility modes picked by the straps
  typedef enum logic [1:0] {
    FDCSM_MODE_STD,
    FDCSM_MODE_ALT,
    FDCSM_MODE_LEGACY
  } fdcsm_mode_t;

  // ============================================================
  // Data rates selected by the controller core
  typedef enum logic [2:0] {
    FDCSM_RATE_250K,
    FDCSM_RATE_300K,
    FDCSM_RATE_500K,
    FDCSM_RATE_1M,
    FDCSM_RATE_2M
  } fdcsm_rate_t;

  // ============================================================
  // Strap capture sequence
  typedef enum logic {
    FDCSM_ST_SETTLE,
    FDCSM_ST_LOCKED
  } fdcsm_state_t;

endpackage : fdcsm_pkg

// [include/fdcsm_pin_if.sv]
// Synchronised pin levels passed from the input stage to the mode logic
interface fdcsm_pin_if;
  logic ident;
  logic mode2;
  logic term_cnt;
  logic index;

  modport src (output ident, output mode2, output term_cnt, output index);
  modport dst (input ident, input mode2, input term_cnt, input index);
endinterface : fdcsm_pin_if

// [hdl/fdcsm_sync.sv]
// Two-stage synchronisers for the asynchronous pin inputs
`include "fdcsm_params.svh"

module fdcsm_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ident_pin,
  input  wire logic mode2_pin,
  input  wire logic term_cnt_pin,
  input  wire logic index_pin,
  fdcsm_pin_if.src  pins
);

  // ============================================================
  // Stage one is read only by stage two, to keep metastability contained
  logic [3:0] stage1;
  logic [3:0] stage2;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= 4'h0;
      stage2 <= 4'h0;
    end
    else
    begin
      stage1 <= {index_pin, term_cnt_pin, mode2_pin, ident_pin};
      stage2 <= stage1;
    end
  end

  // Hand the settled levels on
  assign pins.ident    = stage2[0];
  assign pins.mode2    = stage2[1];
  assign pins.term_cnt = stage2[2];
  assign pins.index    = stage2[3];

endmodule : fdcsm_sync

// [hdl/fdcsm_top.sv]
// Strap-selected system mode, density polarity, idle pin and index logic
//
// How it works
// - Both straps are sampled after reset release and the resulting mode is latched.
// - First mode: honour DMA enable bit, terminal count high, status regs undriven.
// - Second mode: DMA always enabled, terminal count active low.
// - Density select active high for fast rates when strap is 1, else low.
// - Shared pin carries idle indication when power-management bit 4 is set.
// - Idle indication is high while controller idle or powered down.
// - Shared pin carries drive 1 motor enable when bit 4 is clear.
`include "fdcsm_params.svh"

module fdcsm_top (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  ident_strap,
  input  wire logic                  second_mode_strap,
  input  wire logic                  digital_output_reg_dma,
  input  wire logic                  terminal_count_pin,
  input  wire fdcsm_pkg::fdcsm_rate_t data_rate,
  input  wire logic [7:0]            power_mgmt_control_reg,
  input  wire logic                  fdc_idle,
  input  wire logic                  fdc_powerdown,
  input  wire logic                  drive1_motor_enable,
  input  wire logic                  index_pin,
  output fdcsm_pkg::fdcsm_mode_t     op_mode,
  output logic                       mode_locked,
  output logic                       dma_enabled,
  output logic                       terminal_count,
  output logic                       status_oe,
  output logic                       density_select_out,
  output logic                       shared_pin_out,
  output logic                       track_start
);
  import fdcsm_pkg::*;

  // ============================================================
  // Functions
  // Legacy mode only when both straps read low; illegal combo falls to standard
  function automatic fdcsm_mode_t strap_decode(input logic ident, input logic mode2);
    if (!ident && mode2)
      strap_decode = FDCSM_MODE_ALT;
    else if (!ident && !mode2)
      strap_decode = FDCSM_MODE_LEGACY;
    else
      strap_decode = FDCSM_MODE_STD;
  endfunction : strap_decode

  // Rates on which density select is asserted
  function automatic logic is_fast_rate(input fdcsm_rate_t rate);
    is_fast_rate = (rate == FDCSM_RATE_500K) || (rate == FDCSM_RATE_1M) ||
                   (rate == FDCSM_RATE_2M);
  endfunction : is_fast_rate

  // ============================================================
  // Input synchronisers
  fdcsm_pin_if pins ();

  fdcsm_sync u_sync (
    .clk          (clk),
    .reset_n      (reset_n),
    .ident_pin    (ident_strap),
    .mode2_pin    (second_mode_strap),
    .term_cnt_pin (terminal_count_pin),
    .index_pin    (index_pin),
    .pins         (pins.src)
  );

  // ============================================================
  // Strap capture
  // Straps cannot be taken under async reset, so wait for the synchroniser
  // to fill after release and latch once
  fdcsm_state_t state;
  fdcsm_state_t next_state;
  logic [1:0]   settle_cnt;
  logic         ident_latched;
  logic         latch_now;

  assign latch_now  = (state == FDCSM_ST_SETTLE) && (settle_cnt == `FDCSM_STRAP_SETTLE);
  assign mode_locked = (state == FDCSM_ST_LOCKED);

  always_comb
  begin
    next_state = state;
    case (state)
      FDCSM_ST_SETTLE: if (latch_now) next_state = FDCSM_ST_LOCKED;
      FDCSM_ST_LOCKED: next_state = FDCSM_ST_LOCKED;
      default:         next_state = FDCSM_ST_SETTLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state         <= FDCSM_ST_SETTLE;
      settle_cnt    <= 2'd0;
      op_mode       <= FDCSM_MODE_STD;
      ident_latched <= 1'b1;
    end
    else
    begin
      state <= next_state;
      if (!latch_now && state == FDCSM_ST_SETTLE)
        settle_cnt <= settle_cnt + 2'd1;
      if (latch_now)
      begin
        op_mode       <= strap_decode(pins.ident, pins.mode2);
        ident_latched <= pins.ident;
      end
    end
  end

  // ============================================================
  // Mode-dependent DMA, terminal count and status drive
  logic next_dma_enabled;
  logic next_terminal_count;
  logic next_status_oe;

  // Only the alternate mode ignores the DMA bit and inverts terminal count
  assign next_dma_enabled    = (op_mode == FDCSM_MODE_ALT) ? 1'b1
                                                           : digital_output_reg_dma;
  assign next_terminal_count = (op_mode == FDCSM_MODE_ALT) ? !pins.term_cnt
                                                           : pins.term_cnt;
  // Legacy mode drives the status registers; standard keeps them off
  assign next_status_oe      = mode_locked && (op_mode != FDCSM_MODE_STD);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dma_enabled    <= `FDCSM_DMA_EN_RST;
      terminal_count <= `FDCSM_TERM_CNT_RST;
      status_oe      <= `FDCSM_STATUS_OE_RST;
    end
    else
    begin
      dma_enabled    <= next_dma_enabled;
      terminal_count <= next_terminal_count;
      status_oe      <= next_status_oe;
    end
  end

  // ============================================================
  // Density select polarity from the latched identity strap
  logic next_density;

  assign next_density = ident_latched ? is_fast_rate(data_rate)
                                      : !is_fast_rate(data_rate);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      density_select_out <= `FDCSM_DENSITY_RST;
    else
      density_select_out <= next_density;
  end

  // ============================================================
  // Shared idle / motor pin
  logic idle_sel;
  logic next_shared;

  assign idle_sel    = power_mgmt_control_reg[`FDCSM_PWR_IDLE_BIT];
  assign next_shared = idle_sel ? (fdc_idle || fdc_powerdown)
                                : drive1_motor_enable;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      shared_pin_out <= `FDCSM_SHARED_RST;
    else
      shared_pin_out <= next_shared;
  end

  // ============================================================
  // Index edge detect; one pulse per track regardless of pulse width
  logic index_prev;
  logic next_track;

  assign next_track = pins.index && !index_prev;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      index_prev  <= 1'b0;
      track_start <= `FDCSM_TRACK_RST;
    end
    else
    begin
      index_prev  <= pins.index;
      track_start <= next_track;
    end
  end

  // ============================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  mode_held_a: assert property (mode_locked |=> $stable(op_mode) && mode_locked)
    else $error("mode changed after lock");

  lock_time_a: assert property ($rose(reset_n) |-> ##4 mode_locked)
    else $error("straps not latched in time");

  std_dma_a: assert property (op_mode == FDCSM_MODE_STD && mode_locked
                              |=> dma_enabled == $past(digital_output_reg_dma))
    else $error("standard mode ignored DMA bit");

  std_status_a: assert property (op_mode == FDCSM_MODE_STD |=> !status_oe)
    else $error("status driven in standard mode");

  alt_dma_a: assert property (mode_locked && op_mode == FDCSM_MODE_ALT
                              |=> dma_enabled)
    else $error("alternate mode DMA not forced on");

  alt_term_a: assert property (mode_locked && op_mode == FDCSM_MODE_ALT
                               |=> terminal_count == !$past(pins.term_cnt))
    else $error("alternate mode terminal count polarity wrong");

  density_pol_a: assert property (mode_locked && is_fast_rate(data_rate)
                                  |=> density_select_out == $past(ident_latched))
    else $error("density select polarity wrong");

  idle_pin_a: assert property (idle_sel && (fdc_idle || fdc_powerdown)
                               |=> shared_pin_out)
    else $error("idle not shown on shared pin");

  motor_pin_a: assert property (!idle_sel
                                |=> shared_pin_out == $past(drive1_motor_enable))
    else $error("motor enable not on shared pin");

  index_pulse_a: assert property ($rose(pins.index) |=> track_start ##1 !track_start)
    else $error("track start pulse wrong");

  legacy_drive_a: assert property (mode_locked && op_mode == FDCSM_MODE_LEGACY
                                   |=> status_oe && terminal_count == $past(pins.term_cnt))
    else $error("legacy mode behaviour wrong");

endmodule : fdcsm_top

// [tb/fdcsm_drive_model.sv]
// Drive-side model that supplies the track index pulse
module fdcsm_drive_model (
  input  wire logic clk,
  output logic      index_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // Index line
  // Idle low between pulses, so every pulse gives a clean rising edge
  initial index_pin = 1'b0;

  // One index pulse of w cycles, launched just after an edge
  task automatic pulse(int w);
    @(posedge clk);
    #2;
    index_pin = 1'b1;
    repeat (w) @(posedge clk);
    #2;
    index_pin = 1'b0;
  endtask : pulse
endmodule : fdcsm_drive_model

// [tb/test_fdc_system_mode_strap.sv]
// Self-checking bench for the strap-selected system-mode logic
`include "fdcsm_params.svh"

module test_fdc_system_mode_strap;
  timeunit 1ns;
  timeprecision 1ps;
  import fdcsm_pkg::*;

  // ============================================================
  // Signals
  logic        clk = 1'b0, reset_n = 1'b0;
  logic        ident_strap = 1'b1, second_mode_strap = 1'b1;
  logic        digital_output_reg_dma = 1'b0, terminal_count_pin = 1'b0;
  logic        fdc_idle = 1'b0, fdc_powerdown = 1'b0, drive1_motor_enable = 1'b0;
  logic        index_pin;
  logic [7:0]  power_mgmt_control_reg = 8'h00;
  fdcsm_rate_t data_rate = FDCSM_RATE_250K;
  fdcsm_mode_t op_mode;
  logic        mode_locked, dma_enabled, terminal_count, status_oe;
  logic        density_select_out, shared_pin_out, track_start;
  int          err_total = 0, total_checks = 0, cyc = 0, hits = 0;

  fdcsm_top i_dut (.clk, .reset_n, .ident_strap, .second_mode_strap, .digital_output_reg_dma,
    .terminal_count_pin, .data_rate, .power_mgmt_control_reg, .fdc_idle, .fdc_powerdown,
    .drive1_motor_enable, .index_pin, .op_mode, .mode_locked, .dma_enabled,
    .terminal_count, .status_oe, .density_select_out, .shared_pin_out, .track_start);

  fdcsm_drive_model i_drive (.clk, .index_pin);

  // ============================================================
  // Clock, hang guard and pulse counter
  always #10 clk = ~clk;

  // Twenty thousand cycles is ample for four strap passes
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  // Counted mid-cycle, away from the edge that updates it
  always @(negedge clk) hits += (track_start === 1'b1);

  // ============================================================
  // Helpers
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic chk(logic [2:0] got, logic [2:0] exp, string what);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : chk

  function automatic fdcsm_mode_t exp_mode(logic id, logic m2);
    return id ? FDCSM_MODE_STD : (m2 ? FDCSM_MODE_ALT : FDCSM_MODE_LEGACY);
  endfunction : exp_mode

  function automatic logic exp_dens(logic id, fdcsm_rate_t r);
    logic fast;
    fast = (r == FDCSM_RATE_500K) || (r == FDCSM_RATE_1M) || (r == FDCSM_RATE_2M);
    return id ? fast : ~fast;
  endfunction : exp_dens

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // ============================================================
  // Main sequence: one pass per strap pair, illegal pair included
  initial
  begin
    fdcsm_mode_t m;
    logic [1:0]  s;
    logic        want;
    void'($urandom(32'h2fda));
    for (int c = 0; c < 4; c++)
    begin
      s = 2'(c);
      reset_n = 1'b0;
      ident_strap = s[1];
      second_mode_strap = s[0];
      tick(c == 0 ? 10 : 2);
      reset_n = 1'b1;
      m = exp_mode(s[1], s[0]);
      tick(3);
      chk({2'b0, mode_locked}, 3'h0, "lock early");
      tick(1);
      chk({2'b0, mode_locked}, 3'h1, "lock");
      // Flipped straps after lock must change nothing
      ident_strap = ~s[1];
      second_mode_strap = ~s[0];
      for (int k = 0; k < 10; k++)
      begin
        digital_output_reg_dma = 1'($urandom);
        terminal_count_pin = 1'($urandom);
        data_rate = fdcsm_rate_t'(k < 5 ? k : $urandom_range(4));
        // Terminal count crosses two sync flops, so allow four edges
        tick(4);
        chk({1'b0, op_mode}, {1'b0, m}, "mode");
        want = (m == FDCSM_MODE_ALT) ? 1'b1 : digital_output_reg_dma;
        chk({2'b0, dma_enabled}, {2'b0, want}, "dma");
        want = (m == FDCSM_MODE_ALT) ? ~terminal_count_pin : terminal_count_pin;
        chk({2'b0, terminal_count}, {2'b0, want}, "term count");
        chk({2'b0, status_oe}, {2'b0, m != FDCSM_MODE_STD}, "status");
        want = exp_dens(s[1], data_rate);
        chk({2'b0, density_select_out}, {2'b0, want}, "density");
      end
      // Shared pin, both selections alternating
      for (int k = 0; k < 16; k++)
      begin
        power_mgmt_control_reg = 8'($urandom);
        power_mgmt_control_reg[`FDCSM_PWR_IDLE_BIT] = k[0];
        fdc_idle = 1'($urandom);
        fdc_powerdown = 1'($urandom);
        drive1_motor_enable = 1'($urandom);
        tick(1);
        want = k[0] ? (fdc_idle | fdc_powerdown) : drive1_motor_enable;
        chk({2'b0, shared_pin_out}, {2'b0, want}, "shared pin");
      end
      // Index pulses of several widths each give one track start
      for (int w = 1; w < 4; w++)
      begin
        hits = 0;
        i_drive.pulse(w);
        tick(6);
        chk(3'(hits), 3'h1, "track start");
      end
    end
    summarize();
  end
endmodule : test_fdc_system_mode_strap
